/* File: logic/dscp_pkg.sv */
// Package: constants and types of the DAC serial control port
package dscp_pkg;
  localparam logic [5:0] DEV_ADDR      = 6'h05;
  localparam logic [1:0] TYPE_FEATURE  = 2'h0;
  localparam logic [1:0] TYPE_CONTROL  = 2'h2;
  localparam int         BYTE_BITS     = 8;
  localparam logic [1:0] FEAT_VOL_R    = 2'h0;
  localparam logic [1:0] FEAT_VOL_L    = 2'h1;
  localparam logic [1:0] FEAT_BASS     = 2'h2;
  localparam logic [1:0] FEAT_TREBLE   = 2'h3;
  localparam logic [7:0] CTL0_RESET    = 8'h00;
  localparam logic [7:0] CTL1_RESET    = 8'h90;
  localparam int         CTL0_MUTE_BIT = 1;
  localparam int         CTL1_SPD_LSB  = 5;
  localparam logic [15:0] LOCK_N0      = 16'd512;
  localparam logic [15:0] LOCK_N1      = 16'd2048;
  localparam logic [15:0] LOCK_N2      = 16'd4096;
  localparam logic [15:0] LOCK_N3      = 16'd16348;
  localparam int         RAMP_COEFS    = 32;
  localparam int         RAMP_REPS     = 32;
  localparam int         CLK_HZ        = 25000000;
  localparam logic [11:0] DOM1_CYC     = 12'(CLK_HZ / 12000);
  localparam logic [11:0] DOM2_CYC     = 12'(CLK_HZ / 25000);
  localparam logic [11:0] DOM3_CYC     = 12'(CLK_HZ / 40000);
  localparam int         OSR           = 128;

  typedef struct packed {
    logic [5:0] vol_r;
    logic [5:0] vol_l;
    logic [4:0] bass;
    logic [4:0] treble;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
  } dscp_regs_t;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dscp_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DATA   = 3'b100
  } dscp_state_t;
endpackage : dscp_pkg

/* File: logic/dscp_fifo.sv */
// Sample FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dscp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic             full;
  logic             empty;
  assign full        = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty       = (wp_ff == rp_ff);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rp_ff[AW-1:0]];
  always_ff @(posedge mclk_i) begin
    if (in_valid_i && !full) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (in_valid_i && !full) wp_ff <= wp_ff + 1'b1;
      if (out_ready_i && !empty) rp_ff <= rp_ff + 1'b1;
    end
  end
  a_fifo_no_overrun: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    full |=> !(wp_ff != $past(wp_ff) && rp_ff == $past(rp_ff)))
    else $error("fifo written while full");
endmodule : dscp_fifo

/* File: logic/dscp_top.sv */
// Serial control port and playback timing of the asynchronous DAC
// Overview of operation
// - Mode low plus 8 clock pulses forms one address byte.
// - Address bits 1:0 pick type: 00 feature, 10 control, others unused.
// - Address bits 7:2 are device address; respond only to 000101.
// - Any other device address deselects; data ignored until readdressed.
// - Selection and type hold over all data bytes until next address.
// - Mode high plus 8 clock pulses forms one data byte.
// - Data byte commits only after its eighth bit arrives.
// - Write only: data line never driven, no readback.
// - Feature type: data bits 7:6 select one of 4 registers.
// - Second selection uses bit 7, plus bit 6 for feature type.
// - Digital PLL recovers sample rate from sample arrivals, times stages.
// - Output muted while unlocked; lock releases mute after 32 samples at zero gain, then gain steps to 1 of 32.
// - Incoming samples pass through a FIFO to remove arrival jitter.
// - Tone domain chosen automatically from rate: 5-12,12-25,25-40,40-55 kHz.
// - Upsampling stages raise stream to 128 times sample rate.
// - Third-order noise shaper makes a one-bit stream.
// - Bits 7:6: 00 right, 01 left volume, 10 bass, 11 treble.
// - Control type: bit 7 clear writes reg 0, set writes reg 1.
// - Lock speed picks 512, 2048, 4096 or 16348 samples.
// - Soft mute: 32 coefficients, each 32 samples; on release gain stays zero through the count, then steps to 1 of 32.
`timescale 1ns/10ps
module dscp_top
  import dscp_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  input  wire logic               ctl_serial_clock_i,
  input  wire logic               ctl_phase_select_i,
  input  wire logic               ctl_serial_data_i,
  input  wire dscp_pkg::dscp_sample_t sample_i,
  input  wire logic               sample_valid_i,
  output logic                    sample_ready_o,
  output dscp_pkg::dscp_regs_t    regs_o,
  output logic                    selected_o,
  output logic                    pll_locked_o,
  output logic                    muted_o,
  output logic [1:0]              tone_domain_o,
  output logic                    os_tick_o,
  output logic                    bitstream_l_o,
  output logic                    bitstream_r_o
);
  import dscp_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [2:0] sck_sync_ff;
  logic [1:0] mode_sync_ff;
  logic [1:0] sdat_sync_ff;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sck_sync_ff  <= 3'h7;
      mode_sync_ff <= '0;
      sdat_sync_ff <= '0;
    end else begin
      sck_sync_ff  <= {sck_sync_ff[1:0], ctl_serial_clock_i};
      mode_sync_ff <= {mode_sync_ff[0], ctl_phase_select_i};
      sdat_sync_ff <= {sdat_sync_ff[0], ctl_serial_data_i};
    end
  end
  logic sck_rise;
  logic mode_s;
  logic sdat_s;
  assign sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
  assign mode_s   = mode_sync_ff[1];
  assign sdat_s   = sdat_sync_ff[1];

  // ==========================================================
  // Serial byte receiver
  dscp_state_t state_ff;
  logic [7:0]  shift_ff;
  logic [3:0]  bitcnt_ff;
  logic        byte_done;
  logic [7:0]  nxt_byte;
  assign nxt_byte  = {sdat_s, shift_ff[7:1]};
  assign byte_done = sck_rise && (bitcnt_ff == 4'(BYTE_BITS - 1));
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_ff  <= ST_IDLE;
      shift_ff  <= '0;
      bitcnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          state_ff  <= mode_s ? ST_DATA : ST_ADDR;
          bitcnt_ff <= '0;
        end
        ST_ADDR, ST_DATA: begin
          if ((state_ff == ST_DATA) != mode_s) begin
            state_ff  <= ST_IDLE;
            bitcnt_ff <= '0;
          end else if (sck_rise) begin
            shift_ff  <= nxt_byte;
            bitcnt_ff <= byte_done ? 4'h0 : bitcnt_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  logic addr_done;
  logic data_done;
  assign addr_done = byte_done && state_ff == ST_ADDR && !mode_s;
  assign data_done = byte_done && state_ff == ST_DATA && mode_s;

  // ==========================================================
  // Address decode and register writes
  logic       sel_ff;
  logic [1:0] type_ff;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sel_ff  <= 1'b0;
      type_ff <= TYPE_FEATURE;
    end else if (addr_done) begin
      sel_ff  <= (nxt_byte[7:2] == DEV_ADDR);
      type_ff <= nxt_byte[1:0];
    end
  end
  assign selected_o = sel_ff;

  dscp_regs_t regs_ff;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      regs_ff <= '{vol_r: '0, vol_l: '0, bass: '0, treble: '0,
                   ctl0: CTL0_RESET, ctl1: CTL1_RESET};
    end else if (data_done && sel_ff) begin
      if (type_ff == TYPE_FEATURE) begin
        case (nxt_byte[7:6])
          FEAT_VOL_R:  regs_ff.vol_r  <= nxt_byte[5:0];
          FEAT_VOL_L:  regs_ff.vol_l  <= nxt_byte[5:0];
          FEAT_BASS:   regs_ff.bass   <= nxt_byte[4:0];
          FEAT_TREBLE: regs_ff.treble <= nxt_byte[4:0];
          default:     regs_ff.treble <= regs_ff.treble;
        endcase
      end else if (type_ff == TYPE_CONTROL) begin
        if (nxt_byte[7]) regs_ff.ctl1 <= nxt_byte;
        else             regs_ff.ctl0 <= nxt_byte;
      end
    end
  end
  assign regs_o = regs_ff;
  // No output drives the serial data line

  // ==========================================================
  // Sample FIFO
  dscp_sample_t fifo_data;
  logic         fifo_valid;
  logic         fifo_pop;
  dscp_fifo #(.WIDTH($bits(dscp_sample_t)), .DEPTH(16)) u_fifo (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .in_data_i   (sample_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );
  // Every offered sample counts, so a full FIFO cannot stall lock
  logic arrive;
  assign arrive = sample_valid_i;

  // ==========================================================
  // Digital PLL: period measurement and lock
  logic [11:0] per_cnt_ff;
  logic [11:0] period_ff;
  logic [15:0] lock_cnt_ff;
  logic        lock_ff;
  logic [15:0] lock_need;
  function automatic logic [15:0] lock_len(input logic [1:0] spd);
    case (spd)
      2'h0:    lock_len = LOCK_N0;
      2'h1:    lock_len = LOCK_N1;
      2'h2:    lock_len = LOCK_N2;
      default: lock_len = LOCK_N3;
    endcase
  endfunction : lock_len
  assign lock_need = lock_len(regs_ff.ctl1[CTL1_SPD_LSB +: 2]);
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      per_cnt_ff  <= '0;
      period_ff   <= '0;
      lock_cnt_ff <= '0;
      lock_ff     <= 1'b0;
    end else if (arrive) begin
      per_cnt_ff <= 12'h001;
      period_ff  <= per_cnt_ff;
      if ((per_cnt_ff > period_ff + 12'h004) || (per_cnt_ff + 12'h004 < period_ff)) begin
        lock_cnt_ff <= '0;
        lock_ff     <= 1'b0;
      end else if (lock_cnt_ff >= lock_need - 16'h1) begin
        lock_ff <= 1'b1;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 16'h1;
      end
    end else if (per_cnt_ff != 12'hfff) begin
      per_cnt_ff <= per_cnt_ff + 12'h001;
    end else begin
      lock_ff     <= 1'b0;
      lock_cnt_ff <= '0;
    end
  end
  assign pll_locked_o = lock_ff;

  // Tone domain from recovered period
  logic [1:0] dom_ff;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) dom_ff <= '0;
    else if (period_ff > DOM1_CYC) dom_ff <= 2'h0;
    else if (period_ff > DOM2_CYC) dom_ff <= 2'h1;
    else if (period_ff > DOM3_CYC) dom_ff <= 2'h2;
    else dom_ff <= 2'h3;
  end
  assign tone_domain_o = dom_ff;

  // ==========================================================
  // Recovered 128x rate ticks and sample pop
  logic [11:0] os_cnt_ff;
  logic [6:0]  os_idx_ff;
  logic        os_tick;
  assign os_tick = lock_ff && (os_cnt_ff >= (period_ff >> 7));
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      os_cnt_ff <= '0;
      os_idx_ff <= '0;
    end else if (os_tick) begin
      os_cnt_ff <= '0;
      os_idx_ff <= os_idx_ff + 7'h1;
    end else begin
      os_cnt_ff <= os_cnt_ff + 12'h1;
    end
  end
  assign fifo_pop  = os_tick && (os_idx_ff == 7'(OSR - 1));
  assign os_tick_o = os_tick;

  // ==========================================================
  // Soft mute ramp
  logic       mute_req;
  logic [4:0] coef_ff;
  logic [4:0] rep_ff;
  logic       at_zero_ff;
  assign mute_req = !lock_ff || regs_ff.ctl0[CTL0_MUTE_BIT];
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      coef_ff    <= 5'(RAMP_COEFS - 1);
      rep_ff     <= '0;
      at_zero_ff <= 1'b1;
    end else if (!lock_ff) begin
      at_zero_ff <= 1'b1;
      coef_ff    <= 5'(RAMP_COEFS - 1);
    end else if (fifo_pop && (mute_req != at_zero_ff)) begin
      rep_ff <= rep_ff + 5'h1;
      if (rep_ff == 5'(RAMP_REPS - 1)) begin
        if (coef_ff == 5'(RAMP_COEFS - 1)) begin
          coef_ff    <= '0;
          at_zero_ff <= mute_req;
        end else begin
          coef_ff <= coef_ff + 5'h1;
        end
      end
    end
  end
  assign muted_o = at_zero_ff;
  logic [5:0] gain;
  assign gain = at_zero_ff ? 6'h00 :
                (mute_req ? 6'(RAMP_COEFS) - 6'(coef_ff) : 6'(coef_ff) + 6'h1);

  // ==========================================================
  // Held sample and third-order noise shapers
  dscp_sample_t hold_ff;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) hold_ff <= '0;
    else if (fifo_pop && fifo_valid) hold_ff <= fifo_data;
  end
  function automatic logic [15:0] scale(input logic [15:0] s, input logic [5:0] g);
    logic [21:0] p;
    p = 22'($signed(s) * $signed({1'b0, g}));
    scale = p[20:5];
  endfunction : scale
  logic [1:0] bs_bits;
  dscp_ns3 #(.W(16)) u_ns_l (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(os_tick),
    .x_i(scale(hold_ff.left, gain)), .bit_o(bs_bits[0]));
  dscp_ns3 #(.W(16)) u_ns_r (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(os_tick),
    .x_i(scale(hold_ff.right, gain)), .bit_o(bs_bits[1]));
  assign bitstream_l_o = bs_bits[0];
  assign bitstream_r_o = bs_bits[1];

  // ==========================================================
  // Checks
  sequence s_addr_hit;
    addr_done && nxt_byte[7:2] == DEV_ADDR;
  endsequence
  a_addr_select: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s_addr_hit |=> sel_ff) else $error("device not selected");
  a_addr_deselect: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    addr_done && nxt_byte[7:2] != DEV_ADDR |=> !sel_ff) else $error("foreign selected");
  a_sel_holds: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !addr_done |=> $stable(sel_ff) && $stable(type_ff)) else $error("selection moved");
  a_partial_none: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !data_done |=> $stable(regs_ff)) else $error("write without full byte");
  a_unused_type: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    type_ff[0] |=> $stable(regs_ff)) else $error("unused type wrote");
  a_ctl_pick: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    data_done && sel_ff && type_ff == TYPE_CONTROL && nxt_byte[7]
    |=> regs_ff.ctl1 == $past(nxt_byte)) else $error("ctl1 not written");
  a_vol_pick: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    data_done && sel_ff && type_ff == TYPE_FEATURE && nxt_byte[7:6] == FEAT_VOL_L
    |=> regs_ff.vol_l == $past(nxt_byte[5:0])) else $error("left volume lost");
  a_unlock_mute: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !lock_ff |=> at_zero_ff) else $error("unmuted while unlocked");
  a_pop_rate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fifo_pop |=> (!fifo_pop) [*8]) else $error("pop off 128x grid");
endmodule : dscp_top

/* File: logic/dscp_ns3.sv */
// Third-order one-bit noise shaper
`timescale 1ns/10ps
module dscp_ns3 #(
  parameter int W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] x_i,
  output logic              bit_o
);
  localparam int AW = W + 6;
  initial begin
    if (W < 4) $error("W too small");
  end
  logic signed [AW-1:0] i1_ff;
  logic signed [AW-1:0] i2_ff;
  logic signed [AW-1:0] i3_ff;
  logic signed [AW-1:0] fb;
  logic signed [AW-1:0] xs;
  assign xs = AW'($signed(x_i));
  assign fb = bit_o ? AW'(2 ** (W - 1)) : -AW'(2 ** (W - 1));
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      i1_ff <= '0;
      i2_ff <= '0;
      i3_ff <= '0;
      bit_o <= 1'b0;
    end else if (en_i) begin
      i1_ff <= i1_ff + xs - fb;
      i2_ff <= i2_ff + i1_ff - fb;
      i3_ff <= i3_ff + i2_ff - fb;
      bit_o <= !i3_ff[AW-1];
    end
  end
endmodule : dscp_ns3

/* File: verif/dscp_ctl_master.sv */
// Controller model driving the three control lines of the port
`timescale 1ns/10ps
module dscp_ctl_master (
  output logic ctl_serial_clock_o,
  output logic ctl_phase_select_o,
  output logic ctl_serial_data_o
);
  localparam int HALF_NS = 160;
  localparam int SKEW_NS = 13;

  initial begin
    ctl_serial_clock_o = 1'b1;
    ctl_phase_select_o = 1'b0;
    ctl_serial_data_o  = 1'b0;
  end

  // ==========================================================================
  // Byte transfer, clock idles high between frames
  task automatic send_bits(input logic mode, input logic [7:0] b, input int nbits);
    #(SKEW_NS);
    ctl_phase_select_o = mode;
    #(HALF_NS);
    for (int i = 0; i < nbits; i++) begin
      ctl_serial_clock_o = 1'b0;
      ctl_serial_data_o  = b[i];
      #(HALF_NS);
      ctl_serial_clock_o = 1'b1;
      #(HALF_NS);
    end
    ctl_serial_data_o = ~ctl_serial_data_o;       // Data no longer held
    #(HALF_NS);
  endtask : send_bits
endmodule : dscp_ctl_master

/* File: verif/tb_dac_serial_control_port.sv */
// Self-checking bench for the DAC serial control port
`timescale 1ns/10ps
module tb_dac_serial_control_port;
  import dscp_pkg::*;
  localparam int LIMIT = 20000;
  logic         mclk, nrst, sclk, phase, sdata, svalid, sready;
  logic         selected, locked, muted, os_tick, bs_l, bs_r;
  logic [1:0]   tdom;
  dscp_sample_t sample;
  dscp_regs_t   regs, m_regs;
  logic [31:0]  rs, r;
  logic [1:0]   m_typ;
  int           m_sel, n_fail, num_checks, cyc, n;
  logic [7:0]   foreign[$] = {8'h15, 8'h17, 8'h18, 8'ha0, 8'h00};

  dscp_top i_dut (.mclk_i(mclk), .nrst_i(nrst), .ctl_serial_clock_i(sclk),
    .ctl_phase_select_i(phase), .ctl_serial_data_i(sdata), .sample_i(sample),
    .sample_valid_i(svalid), .sample_ready_o(sready), .regs_o(regs),
    .selected_o(selected), .pll_locked_o(locked), .muted_o(muted),
    .tone_domain_o(tdom), .os_tick_o(os_tick), .bitstream_l_o(bs_l),
    .bitstream_r_o(bs_r));
  dscp_ctl_master i_master (.ctl_serial_clock_o(sclk), .ctl_phase_select_o(phase),
    .ctl_serial_data_o(sdata));

  // ==========================================================================
  // Clock, timeout and helpers
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // One serial byte plus reference model update
  task automatic send(input logic mode, input logic [7:0] b);
    i_master.send_bits(mode, b, 8);
    if (!mode) begin
      m_sel = int'(b[7:2] == DEV_ADDR);
      m_typ = b[1:0];
    end else if (m_sel != 0 && m_typ == TYPE_FEATURE) begin
      case (b[7:6])
        FEAT_VOL_R: m_regs.vol_r = b[5:0];
        FEAT_VOL_L: m_regs.vol_l = b[5:0];
        FEAT_BASS:  m_regs.bass = b[4:0];
        default:    m_regs.treble = b[4:0];
      endcase
    end else if (m_sel != 0 && m_typ == TYPE_CONTROL) begin
      if (b[7]) begin
        m_regs.ctl1 = b;
      end else begin
        m_regs.ctl0 = b;
      end
    end
    repeat (2) @(posedge mclk);
    #1;
    check("regs", 40'(regs), 40'(m_regs));
    if (!mode && !b[0]) begin
      check("selected", 40'(selected), 40'(m_sel));
    end
  endtask : send

  // ==========================================================================
  // Main sequence
  initial begin
    rs = 32'h40;
    nrst = 1'b0;
    svalid = 1'b0;
    sample = '0;
    m_regs = '{default: '0, ctl0: CTL0_RESET, ctl1: CTL1_RESET};
    m_sel = 0;
    m_typ = 2'h0;
    repeat (4) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("reset_regs", 40'(regs), 40'(m_regs));
    check("reset_mute", 40'(muted), 40'h1);
    check("reset_lock", 40'(locked), 40'h0);
    send(1'b0, 8'h14);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      send(1'b1, {2'(i), r[5:0]});
    end
    send(1'b0, 8'h16);
    r = rnd();
    send(1'b1, {1'b0, r[6:2], 2'h0});
    r = rnd();
    send(1'b1, 8'h90 | {6'h0, r[1:0]});
    i_master.send_bits(1'b1, 8'h3f, 5);
    send(1'b0, 8'h14);
    foreach (foreign[k]) begin
      send(1'b0, foreign[k]);
      r = rnd();
      send(1'b1, r[7:0]);
    end
    send(1'b0, 8'h14);
    send(1'b1, 8'h45);
    n = 0;
    for (int k = 0; k < 30; k++) begin
      sample = dscp_sample_t'(rnd());
      svalid = 1'b1;
      #10;
      if (sready === 1'b1) begin
        n++;
      end
      @(posedge mclk);
      #1 svalid = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
    end
    check("fifo_fill", 40'(n), 40'd16);
    check("unlocked_mute", 40'(muted), 40'h1);
    check("unlocked_tick", 40'(os_tick), 40'h0);
    check("unlocked", 40'(locked), 40'h0);
    check("buf_full", 40'(sready), 40'h0);
    check("tone_dom", 40'(tdom), 40'h3);
    check("idle_bits_l", 40'(bs_l), 40'h0);
    check("idle_bits_r", 40'(bs_r), 40'h0);
    for (int k = 0; k < 500; k++) begin
      sample = dscp_sample_t'(rnd());
      svalid = 1'b1;
      @(posedge mclk);
      #1 svalid = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      if (k == 470) begin
        check("lock_early", 40'(locked), 40'h0);
      end
    end
    check("locked", 40'(locked), 40'h1);
    check("locked_tick", 40'(os_tick), 40'h1);
    check("locked_ramp", 40'(muted), 40'h1);
    complete_run();
  end
endmodule : tb_dac_serial_control_port
